// ==== core/csi_top.sv ====
// Charger control, status and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "csi_regs.svh"

module csi_top
  import csi_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire csi_req_t    req_in,
  output csi_rsp_t         rsp_out,
  input  wire csi_status_t status_in,
  output csi_ctrl_t        ctrl_out,
  output logic             interrupt_request_n_out,
  output logic             interrupt_request_n_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]                ctrl;
    logic [7:0]                enable;
    logic [`CSI_GRP_COUNT-1:0] arm;
    logic [`CSI_GRP_COUNT-1:0] pending;
    logic [7:0]                rdata;
    logic                      rvalid;
  } csi_top_state_t;

  csi_top_state_t state_q;
  csi_top_state_t state_d;

  // Address match, used by write and read decode
  function automatic logic csi_hit(input logic [7:0] addr, input logic [7:0] off);
    csi_hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Event detection

  logic [`CSI_LVL_COUNT-1:0]  levels;
  logic [`CSI_LVL_COUNT-1:0]  rises;
  logic [`CSI_LVL_COUNT-1:0]  falls;
  logic [7:0]                 events;
  logic [`CSI_GRP_COUNT-1:0]  grp_set;
  logic                       timer_expired;

  assign timer_expired = status_in.overall_timer_expired
                       | status_in.precondition_timer_expired;

  // Level order: timer, temperature, input, end-of-charge, precondition timer
  assign levels = {status_in.overall_timer_expired,
                   status_in.temperature_ok,
                   status_in.input_valid,
                   status_in.end_of_charge,
                   status_in.precondition_timer_expired};

  csi_edge_det u_edge (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .level_in (levels),
    .rise_out (rises),
    .fall_out (falls)
  );

  // Events laid out like the enable register bits
  assign events[7] = rises[4];
  assign events[6] = rises[3];
  assign events[5] = rises[2];
  assign events[4] = rises[1];
  assign events[3] = rises[0];
  assign events[2] = falls[3];
  assign events[1] = falls[2];
  assign events[0] = falls[1];

  // Group set: either enabled event of the group, gated by its arm bit
  genvar g;
  generate
    for (g = 0; g < `CSI_GRP_COUNT; g = g + 1) begin : g_grp
      assign grp_set[g] = state_q.arm[g]
                        & ((events[g + 4] & state_q.enable[g + 4])
                        |  (events[g] & state_q.enable[g]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register access and pending flags

  always_comb begin
    state_d        = state_q;
    state_d.rvalid = req_in.rd;

    // Writes
    if (req_in.wr) begin
      if (csi_hit(req_in.addr, `CSI_ADDR_CTRL)) begin
        state_d.ctrl = req_in.wdata;
      end
      if (csi_hit(req_in.addr, `CSI_ADDR_IRQ_STATUS)) begin
        state_d.arm = req_in.wdata[`CSI_STAT_ARM_HI:`CSI_STAT_ARM_LO];
      end
      if (csi_hit(req_in.addr, `CSI_ADDR_IRQ_ENABLE)) begin
        state_d.enable = req_in.wdata;
      end
    end

    // Reads capture data; a status read clears pending
    if (req_in.rd) begin
      state_d.rdata = `CSI_RST_BYTE;
      if (csi_hit(req_in.addr, `CSI_ADDR_CTRL)) begin
        state_d.rdata = state_q.ctrl;
      end
      if (csi_hit(req_in.addr, `CSI_ADDR_IRQ_STATUS)) begin
        state_d.rdata[`CSI_STAT_ARM_HI:`CSI_STAT_ARM_LO] = state_q.pending;
        state_d.rdata[`CSI_STAT_TIMER] = timer_expired;
        state_d.rdata[`CSI_STAT_TEMP]  = status_in.temperature_ok;
        state_d.rdata[`CSI_STAT_INPUT] = status_in.input_valid;
        state_d.rdata[`CSI_STAT_EOC]   = status_in.end_of_charge;
        state_d.pending = `CSI_RST_GRP;
      end
      if (csi_hit(req_in.addr, `CSI_ADDR_IRQ_ENABLE)) begin
        state_d.rdata = state_q.enable;
      end
      if (csi_hit(req_in.addr, `CSI_ADDR_STATE_RB)) begin
        state_d.rdata[`CSI_RB_STATE_HI:`CSI_RB_STATE_LO] =
          status_in.charging_state_code;
        state_d.rdata[`CSI_RB_AUX] = status_in.aux_supply_level;
      end
    end

    // New events win over a clearing read in the same cycle
    state_d.pending = state_d.pending | grp_set;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q.ctrl    <= `CSI_RST_CTRL;
      state_q.enable  <= `CSI_RST_ENABLE;
      state_q.arm     <= `CSI_RST_GRP;
      state_q.pending <= `CSI_RST_GRP;
      state_q.rdata   <= `CSI_RST_BYTE;
      state_q.rvalid  <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Settings to the charger core
  assign ctrl_out.charge_suspend = state_q.ctrl[`CSI_CTRL_SUSPEND];
  assign ctrl_out.overall_timeout_select =
    state_q.ctrl[`CSI_CTRL_TOTAL_HI:`CSI_CTRL_TOTAL_LO];
  assign ctrl_out.precondition_timeout_select =
    state_q.ctrl[`CSI_CTRL_PRE_HI:`CSI_CTRL_PRE_LO];
  assign ctrl_out.input_overvoltage_select =
    state_q.ctrl[`CSI_CTRL_OVP_HI:`CSI_CTRL_OVP_LO];

  // Read answer
  assign rsp_out.data  = state_q.rdata;
  assign rsp_out.valid = state_q.rvalid;

  // Interrupt pin pulls while any group is pending
  csi_od_pin u_irq_pin (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .assert_in  (|state_q.pending),
    .pin_out    (interrupt_request_n_out),
    .pin_oe_out (interrupt_request_n_oe_out)
  );

endmodule

`default_nettype wire

// ==== inc/csi_regs.svh ====
// Register offsets, field positions and reset values of the charger status block
//
// Function
// - Control bit 7 one halts charging
// - Control 5:4 and 3:2 select safety times
// - Control 1:0 selects input overvoltage level
// - Overall timeout interrupt needs enable and arm
// - Precharge timeout interrupt needs enable and arm
// - Temperature entry interrupt needs enable and arm
// - Temperature exit interrupt needs enable and arm
// - Input valid interrupt needs enable and arm
// - Input invalid interrupt needs enable and arm
// - End-of-charge entry interrupt needs enable and arm
// - End-of-charge exit interrupt needs enable and arm
// - Status 7:4 read pending, write arms
// - Status bit 3 shows any timer expiry
// - Status bit 2 shows temperature in range
// - Status bit 1 shows valid charger input
// - Status bit 0 shows end-of-charge state
// - Readback 5:4 shows charging state code
// - Readback bit 1 shows auxiliary supply comparator
// - Interrupt pin is active-low open drain
`ifndef CSI_REGS_SVH
`define CSI_REGS_SVH

// Register offsets
`define CSI_ADDR_RSVD_A      8'h70
`define CSI_ADDR_CTRL        8'h71
`define CSI_ADDR_IRQ_STATUS  8'h78
`define CSI_ADDR_IRQ_ENABLE  8'h79
`define CSI_ADDR_STATE_RB    8'h7A

// Control register fields
`define CSI_CTRL_SUSPEND     7
`define CSI_CTRL_RSVD        6
`define CSI_CTRL_TOTAL_HI    5
`define CSI_CTRL_TOTAL_LO    4
`define CSI_CTRL_PRE_HI      3
`define CSI_CTRL_PRE_LO      2
`define CSI_CTRL_OVP_HI      1
`define CSI_CTRL_OVP_LO      0

// Status register fields: pending/arm in the upper nibble, levels below
`define CSI_STAT_ARM_HI      7
`define CSI_STAT_ARM_LO      4
`define CSI_STAT_TIMER       3
`define CSI_STAT_TEMP        2
`define CSI_STAT_INPUT       1
`define CSI_STAT_EOC         0

// Readback register fields
`define CSI_RB_STATE_HI      5
`define CSI_RB_STATE_LO      4
`define CSI_RB_AUX           1

// Group indices, also the low event index inside the enable register
`define CSI_GRP_TIMER        3
`define CSI_GRP_TEMP         2
`define CSI_GRP_INPUT        1
`define CSI_GRP_CHARGE       0
`define CSI_GRP_COUNT        4
`define CSI_LVL_COUNT        5

// Reset values
`define CSI_RST_CTRL         8'h00
`define CSI_RST_ENABLE       8'h00
`define CSI_RST_GRP          4'h0
`define CSI_RST_BYTE         8'h00

`endif

// ==== inc/csi_pkg.sv ====
// Types shared by the charger status and interrupt block
`default_nettype none

package csi_pkg;

  // Live levels from the charger core
  typedef struct packed {
    logic       overall_timer_expired;
    logic       precondition_timer_expired;
    logic       temperature_ok;
    logic       input_valid;
    logic       end_of_charge;
    logic [1:0] charging_state_code;
    logic       aux_supply_level;
  } csi_status_t;

  // Settings handed to the charger core
  typedef struct packed {
    logic       charge_suspend;
    logic [1:0] overall_timeout_select;
    logic [1:0] precondition_timeout_select;
    logic [1:0] input_overvoltage_select;
  } csi_ctrl_t;

  // One register access from the serial interface
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } csi_req_t;

  // Register read answer
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } csi_rsp_t;

endpackage

`default_nettype wire

// ==== core/csi_edge_det.sv ====
// Rise and fall detector over the charger status levels
`timescale 1ns/1ps
`default_nettype none
`include "csi_regs.svh"

module csi_edge_det
  import csi_pkg::*;
(
  input  wire logic                        mclk_in,
  input  wire logic                        rst_in,
  input  wire logic [`CSI_LVL_COUNT-1:0]   level_in,
  output logic      [`CSI_LVL_COUNT-1:0]   rise_out,
  output logic      [`CSI_LVL_COUNT-1:0]   fall_out
);

  typedef struct packed {
    logic [`CSI_LVL_COUNT-1:0] prev;
  } csi_edge_state_t;

  csi_edge_state_t state_q;
  csi_edge_state_t state_d;

  // Remember last level
  always_comb begin
    state_d      = state_q;
    state_d.prev = level_in;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Per-level edge terms
  genvar i;
  generate
    for (i = 0; i < `CSI_LVL_COUNT; i = i + 1) begin : g_edge
      assign rise_out[i] = level_in[i] & ~state_q.prev[i];
      assign fall_out[i] = ~level_in[i] & state_q.prev[i];
    end
  endgenerate

endmodule

`default_nettype wire

// ==== core/csi_od_pin.sv ====
// Registered active-low open-drain output driver
`timescale 1ns/1ps
`default_nettype none

module csi_od_pin
  import csi_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic assert_in,
  output logic      pin_out,
  output logic      pin_oe_out
);

  typedef struct packed {
    logic pull;
  } csi_od_state_t;

  csi_od_state_t state_q;
  csi_od_state_t state_d;

  // Pull request follows the assert level
  always_comb begin
    state_d      = state_q;
    state_d.pull = assert_in;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Only ever pulls low, never drives high
  assign pin_out    = 1'b0;
  assign pin_oe_out = state_q.pull;

endmodule

`default_nettype wire

// ==== tb/csi_top_props.sv ====
// Port checker for the charger status block
`timescale 1ns/1ps
`default_nettype none
module csi_top_props
  import csi_pkg::*;
(
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire csi_req_t    req_in,
  input wire csi_rsp_t    rsp_out,
  input wire csi_status_t status_in,
  input wire csi_ctrl_t   ctrl_out,
  input wire logic        interrupt_request_n_out,
  input wire logic        interrupt_request_n_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Decoded accesses and last-cycle levels
  logic        rd78;
  logic        wr71;
  csi_status_t s1;
  assign rd78 = req_in.rd && req_in.addr == 8'h78;
  assign wr71 = req_in.wr && req_in.addr == 8'h71;
  always_ff @(posedge mclk_in) begin
    s1 <= status_in;
  end
  ////////////////////////////////
  // Register port
  property p_rsp; req_in.rd |=> rsp_out.valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no read answer");
  property p_ctrl; wr71 |=> ctrl_out == {s1[7] & 1'b0 | $past(req_in.wdata[7]),
    $past(req_in.wdata[5:0])}; endproperty
  a_ctrl: assert property (p_ctrl) else $error("bad ctrl");
  property p_lvl; rd78 |=> rsp_out.data[3:0] == {s1[7] | s1[6], s1[5:3]}; endproperty
  a_lvl: assert property (p_lvl) else $error("bad levels");
  property p_rb; req_in.rd && req_in.addr == 8'h7A |=>
    rsp_out.data == {2'b00, s1[2:1], 2'b00, s1[0], 1'b0}; endproperty
  a_rb: assert property (p_rb) else $error("bad readback");
  // Interrupt pin
  property p_od; interrupt_request_n_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_clr; rd78 && $stable(status_in) |-> ##2 !interrupt_request_n_oe_out; endproperty
  a_clr: assert property (p_clr) else $error("irq not released");
  property p_fall; $fell(interrupt_request_n_oe_out) |-> $past(rd78, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped early");
  property p_rise; $rose(interrupt_request_n_oe_out) |->
    $past(status_in, 2) != $past(status_in, 3); endproperty
  a_rise: assert property (p_rise) else $error("irq without event");
endmodule
bind csi_top csi_top_props u_props (
  .mclk_in                    (mclk_in),
  .rst_in                     (rst_in),
  .req_in                     (req_in),
  .rsp_out                    (rsp_out),
  .status_in                  (status_in),
  .ctrl_out                   (ctrl_out),
  .interrupt_request_n_out    (interrupt_request_n_out),
  .interrupt_request_n_oe_out (interrupt_request_n_oe_out)
);
`default_nettype wire

// ==== tb/csi_host.sv ====
// Host model issuing byte register accesses
`timescale 1ns/1ps
`default_nettype none
module csi_host
  import csi_pkg::*;
(
  input  wire logic     mclk_in,
  output csi_req_t      req_out,
  input  wire csi_rsp_t rsp_in
);
  initial req_out = '0;
  // Write strobe for one edge, then scrambled idle bus for one full edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_out = '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in);
    #1 req_out = '{~a, ~d, 1'b0, 1'b0};
    @(posedge mclk_in);
    #1;
  endtask
  // Read with bounded wait; flagged levels trusted in input window
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    req_out = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_in);
    #1 req_out = '{~a, 8'hFF, 1'b0, 1'b0};
    n = 0;
    while (rsp_in.valid !== 1'b1 && n < 4) begin
      @(posedge mclk_in);
      #1 n++;
    end
    d = rsp_in.data;
    ok = n < 4;
    // Idle edge so a following access never reassigns the bus in this step
    @(posedge mclk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the charger status block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import csi_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  csi_req_t    req;
  csi_rsp_t    rsp;
  csi_status_t st = '0;
  csi_ctrl_t   ctrl;
  logic        irq_n;
  logic        irq_oe;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          g;
  int          li;
  bit          rise;
  bit          ok;
  logic [7:0]  d;
  logic [7:0]  v;
  logic [4:0]  lv = '0;
  always #5 mclk_in = ~mclk_in;
  csi_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req), .rsp_out(rsp),
    .status_in(st), .ctrl_out(ctrl), .interrupt_request_n_out(irq_n),
    .interrupt_request_n_oe_out(irq_oe));
  csi_host host (.mclk_in(mclk_in), .req_out(req), .rsp_in(rsp));
  ////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      final_report;
    end else begin
      chk($sformatf("reg %h", a), e, d);
    end
  endtask
  // Enable, arm, then move the event level
  task automatic step(input logic [7:0] en, input logic [7:0] arm, input bit hit);
    host.wr(8'h79, en);
    host.wr(8'h78, arm);
    lv[li] = rise;
    st = {lv, 3'b000};
    cyc(3);
    chk("irq", {7'h0, hit}, {7'h0, irq_oe});
    chk("irq pin", 8'h00, {7'h0, irq_n});
  endtask
  task automatic back;
    host.wr(8'h79, 8'h00);
    lv[li] = !rise;
    st = {lv, 3'b000};
    cyc(2);
  endtask
  ////////////////////////////////
  initial begin
    cyc(12);
    rst_in = 1'b0;
    for (int a = 8'h6F; a < 8'h7B; a++) rdc(8'(a), 8'h00);
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h4A : 8'hB5;
      host.wr(8'h71, v);
      chk("ctrl", {1'b0, v[7], v[5:0]}, {1'b0, ctrl});
      host.wr(8'h70, 8'hFF);
      host.wr(8'h79, ~v);
      rdc(8'h71, v);
      rdc(8'h79, ~v);
    end
    rdc(8'h70, 8'h00);
    for (int c = 0; c < 8; c++) begin
      st = {lv, c[2:0]};
      cyc(1);
      rdc(8'h7A, {2'b00, c[2:1], 2'b00, c[0], 1'b0});
    end
    host.wr(8'h79, 8'h00);
    for (int k = 0; k < 8; k++) begin
      g = k % 4;
      li = k == 7 ? 4 : (g == 3 ? 3 : g);
      rise = k >= 4 || g == 3;
      lv = '0;
      lv[li] = !rise;
      st = {lv, 3'b000};
      cyc(2);
      step(8'hFF, 8'hF0 ^ (8'h10 << g), 1'b0);
      back();
      step(~(8'h01 << k), 8'hF0, 1'b0);
      back();
      step(8'h01 << k, 8'hF0,
        1'b1);
      rdc(8'h78, {4'h1 << g, lv[4] | lv[3], lv[2:0]});
      cyc(1);
      chk("irq", 8'h00, {7'h0, irq_oe});
      back();
    end
    rst_in = 1'b1;
    cyc(1);
    chk("ctrl", 8'h00, {1'b0, ctrl});
    rst_in = 1'b0;
    rdc(8'h71, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
